// ---- hdl/lpm_ctrl.sv ----
/*
 * lpm_ctrl: low-power mode controller with an AHB-Lite register slave.
 * Assumes the core drives its requests on hclk; wakeup pins, event lines,
 * watchdog, reset pin and clock events arrive asynchronously.
 */
`timescale 1ns/1ps
module lpm_ctrl
    import lpm_pkg::*;
#(
    parameter int STANDBY_WAKE_CYC = STANDBY_EXIT_CYC
) (
    // clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // core side
    input  wire lpm_core_req_t         core_req,
    input  wire logic                  periph_irq,
    input  wire logic                  periph_hsi_req,
    output logic                       core_wake,
    output logic                       core_rst_n,
    // asynchronous wakeup sources
    input  wire logic [N_EVENT-1:0]    external_event_line,
    input  wire logic [N_PIN-1:0]      wakeup_pin,
    input  wire logic                  external_reset_pin_n,
    input  wire logic                  independent_watchdog_rst,
    input  wire logic [N_RTC_EV-1:0]   rtc_event,
    // power and clock controls, and the interrupt
    output lpm_pwr_t                   pwr,
    output lpm_clk_t                   sysclk_sel,
    output logic                       irq
);

    // ==========================================================
    // declarations
    lpm_state_t        state_q;
    lpm_state_t        state_d;
    logic              from_stby_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [A_W-1:0]    sync1_q;
    logic [A_W-1:0]    sync2_q;
    logic [N_PIN-1:0]  pin_prev_q;
    logic [CFG_W-1:0]  cfg_q;
    logic [IRQ_W-1:0]  stat_q;
    logic [IRQ_W-1:0]  mask_q;
    logic              stby_flag_q;
    logic [SRC_W-1:0]  src_q;
    logic              wr_pend_q;
    logic              rd_pend_q;
    logic [ADDR_W-1:0] addr_q;
    lpm_pwr_t          pwr_d;
    lpm_clk_t          clk_d;
    logic              ev_any;
    logic              pin_rise;
    logic              rtc_any;
    logic              rst_pin;
    logic              wdg_rst;
    logic              stby_wake;
    logic              stop_wake;
    logic              sleep_wake;
    logic              wake_done;
    logic              rd_stat;
    logic              addr_ok;
    logic [SRC_W-1:0]  src_now;

    function automatic logic [31:0] reg_read(input logic [ADDR_W-1:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            OFF_CFG:      v[CFG_W-1:0] = cfg_q;
            OFF_IRQ_STAT: v[IRQ_W-1:0] = stat_q;
            OFF_IRQ_MASK: v[IRQ_W-1:0] = mask_q;
            OFF_CLK_CSR: begin
                v[CSR_STBY_FLAG]                       = stby_flag_q;
                v[CSR_SRC_LSB +: SRC_W]                = src_q;
                v[CSR_STATE_LSB +: $bits(lpm_state_t)] = state_q;
            end
            default:      v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // ==========================================================
    // input synchronisers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q    <= '0;
            sync2_q    <= '0;
            pin_prev_q <= '0;
        end else begin
            sync1_q    <= {rtc_event, independent_watchdog_rst, ~external_reset_pin_n,
                           wakeup_pin, external_event_line};
            sync2_q    <= sync1_q;
            pin_prev_q <= sync2_q[A_PIN_LSB +: N_PIN];
        end
    end

    assign ev_any   = |sync2_q[A_EV_LSB +: N_EVENT];
    assign pin_rise = |(sync2_q[A_PIN_LSB +: N_PIN] & ~pin_prev_q);
    assign rtc_any  = |sync2_q[A_RTC_LSB +: N_RTC_EV];
    assign rst_pin  = sync2_q[A_RST];
    assign wdg_rst  = sync2_q[A_WDG];

    // standby exit sources depend on whether the clock domain is kept
    assign stby_wake = rst_pin | pin_rise | (cfg_q[CFG_RTC] & (wdg_rst | rtc_any));

    assign stop_wake  = (state_q == ST_STOP) && ev_any;
    assign sleep_wake = ((state_q == ST_SLEEP) || (state_q == ST_LP_SLEEP))
                        && (periph_irq || ev_any);
    assign wake_done  = (state_q == ST_WAKE) && (cnt_q == '0);

    always_comb begin
        src_now            = '0;
        src_now[SRC_EVENT] = ev_any;
        src_now[SRC_PIN]   = pin_rise;
        src_now[SRC_RTC]   = rtc_any & cfg_q[CFG_RTC];
        src_now[SRC_WDG]   = wdg_rst & cfg_q[CFG_RTC];
        src_now[SRC_RST]   = rst_pin;
    end

    // ==========================================================
    // mode state machine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN, ST_LP_RUN: begin
                if (core_req.sleep_req) begin
                    if (core_req.deep_sel) begin
                        state_d = cfg_q[CFG_STANDBY] ? ST_STANDBY : ST_STOP;
                    end else if (core_req.lpreg_sel) begin
                        state_d = ST_LP_SLEEP;
                    end else begin
                        state_d = ST_SLEEP;
                    end
                end else if (state_q == ST_RUN && cfg_q[CFG_LP_RUN]) begin
                    state_d = ST_LP_RUN;
                end else if (state_q == ST_LP_RUN && !cfg_q[CFG_LP_RUN]) begin
                    state_d = ST_RUN;
                end
            end
            ST_SLEEP, ST_LP_SLEEP: begin
                if (sleep_wake) begin
                    state_d = ST_RUN;
                end
            end
            ST_STOP: begin
                if (stop_wake) begin
                    state_d = ST_WAKE;
                end
            end
            ST_STANDBY: begin
                if (stby_wake) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (wake_done) begin
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // exit latency counter; slack covers synchroniser and output flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q       <= '0;
            from_stby_q <= 1'b0;
        end else if (stop_wake) begin
            cnt_q       <= CNT_W'(STOP_EXIT_CYC - WAKE_SLACK_CYC);
            from_stby_q <= 1'b0;
        end else if (state_q == ST_STANDBY && stby_wake) begin
            cnt_q       <= CNT_W'(STANDBY_WAKE_CYC - WAKE_SLACK_CYC);
            from_stby_q <= 1'b1;
        end else if (state_q == ST_WAKE && cnt_q != '0) begin
            cnt_q       <= cnt_q - CNT_W'(1);
        end
    end

    // ==========================================================
    // power and clock outputs
    always_comb begin
        pwr_d                    = PWR_RST;
        // full regulator and no multispeed minimum unless a mode asks
        pwr_d.reg_lp             = 1'b0;
        pwr_d.msi_min            = 1'b0;
        clk_d                    = cfg_q[CFG_HSE_SEL] ? CLK_HSE : CLK_HSI;
        pwr_d.reg_on             = 1'b1;
        pwr_d.core_pwr           = 1'b1;
        pwr_d.retain             = 1'b1;
        pwr_d.cpu_clk            = 1'b1;
        pwr_d.periph_clk         = 1'b1;
        pwr_d.high_speed_ext_osc = cfg_q[CFG_HSE_SEL];
        pwr_d.high_speed_int_osc = !cfg_q[CFG_HSE_SEL];
        pwr_d.pll_en             = cfg_q[CFG_PLL];
        // slow clocks, watchdog and display follow configuration; standby forces the display off, and the rest off unless CFG_RTC is set
        pwr_d.low_speed_ext_osc  = cfg_q[CFG_LSE];
        pwr_d.low_speed_int_osc  = cfg_q[CFG_LSI] | cfg_q[CFG_INDEPENDENT_WATCHDOG];
        pwr_d.rtc_clk            = cfg_q[CFG_RTC];
        pwr_d.independent_watchdog_clk           = cfg_q[CFG_INDEPENDENT_WATCHDOG];
        pwr_d.lcd_en             = cfg_q[CFG_LCD];
        unique case (state_q)
            ST_RUN: pwr_d.reg_lp = 1'b0;
            ST_SLEEP: begin
                pwr_d.cpu_clk = 1'b0;
            end
            ST_LP_RUN, ST_LP_SLEEP: begin
                pwr_d.reg_lp             = 1'b1;
                pwr_d.cpu_clk            = (state_q == ST_LP_RUN);
                pwr_d.pll_en             = 1'b0;
                pwr_d.high_speed_ext_osc = 1'b0;
                pwr_d.high_speed_int_osc = 1'b0;
                pwr_d.multispeed_rc_osc  = 1'b1;
                pwr_d.msi_min            = 1'b1;
                clk_d                    = CLK_MSI;
            end
            ST_STOP: begin
                pwr_d.reg_lp             = 1'b1;
                pwr_d.cpu_clk            = 1'b0;
                pwr_d.periph_clk         = 1'b0;
                pwr_d.pll_en             = 1'b0;
                pwr_d.high_speed_ext_osc = 1'b0;
                pwr_d.high_speed_int_osc = periph_hsi_req;
                pwr_d.rtc_clk            = cfg_q[CFG_RTC];
            end
            ST_STANDBY: begin
                pwr_d.reg_on             = 1'b0;
                pwr_d.reg_lp             = 1'b0;
                pwr_d.core_pwr           = 1'b0;
                pwr_d.retain             = 1'b0;
                pwr_d.cpu_clk            = 1'b0;
                pwr_d.periph_clk         = 1'b0;
                pwr_d.pll_en             = 1'b0;
                pwr_d.high_speed_ext_osc = 1'b0;
                pwr_d.high_speed_int_osc = 1'b0;
                pwr_d.lcd_en             = 1'b0;
                if (!cfg_q[CFG_RTC]) begin
                    pwr_d.low_speed_ext_osc = 1'b0;
                    pwr_d.low_speed_int_osc = 1'b0;
                    pwr_d.independent_watchdog_clk          = 1'b0;
                end
            end
            ST_WAKE: begin
                // the exit path always runs from the multispeed oscillator
                pwr_d.cpu_clk            = 1'b0;
                pwr_d.pll_en             = 1'b0;
                pwr_d.high_speed_ext_osc = 1'b0;
                pwr_d.high_speed_int_osc = 1'b0;
                pwr_d.multispeed_rc_osc  = 1'b1;
                clk_d                    = CLK_MSI;
            end
            default: pwr_d = PWR_RST;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr        <= PWR_RST;
            sysclk_sel <= CLK_HSI;
            core_wake  <= 1'b0;
            core_rst_n <= 1'b1;
        end else begin
            pwr        <= pwr_d;
            sysclk_sel <= clk_d;
            core_wake  <= wake_done | sleep_wake;
            // core logic restarts from reset after standby
            core_rst_n <= !((state_q == ST_WAKE) && from_stby_q);
        end
    end

    // ==========================================================
    // AHB-Lite slave: writes zero wait, reads one wait state
    assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign rd_stat = rd_pend_q && (addr_q == OFF_IRQ_STAT);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= '0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= HRESP_OKAY;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            rd_pend_q <= addr_ok && !hwrite;
            hresp     <= HRESP_OKAY;
            if (addr_ok) begin
                addr_q <= haddr[ADDR_W-1:0];
            end
            if (addr_ok && !hwrite) begin
                hreadyout <= 1'b0;
            end else begin
                hreadyout <= 1'b1;
            end
            if (rd_pend_q) begin
                hrdata <= reg_read(addr_q);
            end
        end
    end

    // configuration and mask; both fall back to reset after standby
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q  <= CFG_RST;
            mask_q <= IRQ_RST;
        end else if (state_q == ST_STANDBY && stby_wake) begin
            cfg_q  <= CFG_RST;
            mask_q <= IRQ_RST;
        end else if (wr_pend_q) begin
            if (addr_q == OFF_CFG) begin
                cfg_q <= hwdata[CFG_W-1:0];
            end
            if (addr_q == OFF_IRQ_MASK) begin
                mask_q <= hwdata[IRQ_W-1:0];
            end
        end else if (state_q == ST_LP_SLEEP && sleep_wake) begin
            cfg_q[CFG_LP_RUN] <= 1'b0;
        end
    end

    // interrupt flags: read clears, a new event in that cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= IRQ_RST;
        end else begin
            stat_q <= (rd_stat ? IRQ_RST : stat_q)
                      | {wake_done & from_stby_q, stop_wake, sleep_wake};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_q & mask_q);
        end
    end

    // status survives standby; write one to the flag clears it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stby_flag_q <= 1'b0;
            src_q       <= SRC_RST_VAL;
        end else begin
            if (state_q == ST_STANDBY && stby_wake) begin
                stby_flag_q <= 1'b1;
                src_q       <= src_now;
            end else if (stop_wake) begin
                src_q       <= src_now;
            end else if (wr_pend_q && addr_q == OFF_CLK_CSR
                         && hwdata[CSR_STBY_FLAG]) begin
                stby_flag_q <= 1'b0;
            end
        end
    end

endmodule

// ---- shared/lpm_pkg.sv ----
/*
 * lpm_pkg: constants, types and register map of the low-power mode controller.
 * Assumes a single 250 MHz system clock domain and an AHB-Lite register bus.
 */
package lpm_pkg;

    // ==========================================================
    // clock and exit latencies
    localparam real CLK_MHZ          = 250.0;
    localparam real RUN_MAX_MHZ      = 32.0;
    localparam real LP_RUN_KHZ       = 131.0;
    localparam real STOP_EXIT_US     = 3.5;
    localparam real STANDBY_EXIT_US  = 60.0;
    // longest times round down
    localparam int  STOP_EXIT_CYC    = $rtoi(STOP_EXIT_US * CLK_MHZ);
    localparam int  STANDBY_EXIT_CYC = $rtoi(STANDBY_EXIT_US * CLK_MHZ);
    // cycles lost to input synchronising and output registering
    localparam int  WAKE_SLACK_CYC   = 8;
    localparam int  CNT_W            = 16;

    // ==========================================================
    // register map (byte addresses, 32-bit words)
    localparam int         ADDR_W        = 8;
    localparam logic [7:0] OFF_CFG       = 8'h00;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h04;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h08;
    localparam logic [7:0] OFF_CLK_CSR   = 8'h0C;

    // configuration register fields
    localparam int         CFG_LP_RUN    = 0;
    localparam int         CFG_STANDBY   = 1;
    localparam int         CFG_RTC       = 2;
    localparam int         CFG_INDEPENDENT_WATCHDOG      = 3;
    localparam int         CFG_LCD       = 4;
    localparam int         CFG_HSE_SEL   = 5;
    localparam int         CFG_PLL       = 6;
    localparam int         CFG_LSE       = 7;
    localparam int         CFG_LSI       = 8;
    localparam int         CFG_W         = 9;
    localparam logic [8:0] CFG_RST       = 9'h000;

    // interrupt status and mask fields
    localparam int         IRQ_SLEEP_WAKE = 0;
    localparam int         IRQ_STOP_WAKE  = 1;
    localparam int         IRQ_STBY_WAKE  = 2;
    localparam int         IRQ_W          = 3;
    localparam logic [2:0] IRQ_RST        = 3'h0;

    // clock control status register fields
    localparam int         CSR_STBY_FLAG = 0;
    localparam int         CSR_SRC_LSB   = 4;
    localparam int         CSR_STATE_LSB = 16;
    localparam int         SRC_EVENT     = 0;
    localparam int         SRC_PIN       = 1;
    localparam int         SRC_RTC       = 2;
    localparam int         SRC_WDG       = 3;
    localparam int         SRC_RST       = 4;
    localparam int         SRC_W         = 5;
    localparam logic [4:0] SRC_RST_VAL   = 5'h00;

    // ==========================================================
    // asynchronous wakeup inputs, packed into one synchroniser vector
    localparam int N_EVENT    = 8;
    localparam int N_PIN      = 3;
    localparam int N_RTC_EV   = 5;
    localparam int A_EV_LSB   = 0;
    localparam int A_PIN_LSB  = A_EV_LSB + N_EVENT;
    localparam int A_RST      = A_PIN_LSB + N_PIN;
    localparam int A_WDG      = A_RST + 1;
    localparam int A_RTC_LSB  = A_WDG + 1;
    localparam int A_W        = A_RTC_LSB + N_RTC_EV;

    // ==========================================================
    // AHB-Lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    // ==========================================================
    // types
    typedef enum logic [6:0] {
        ST_RUN      = 7'h01,
        ST_LP_RUN   = 7'h02,
        ST_SLEEP    = 7'h04,
        ST_LP_SLEEP = 7'h08,
        ST_STOP     = 7'h10,
        ST_STANDBY  = 7'h20,
        ST_WAKE     = 7'h40
    } lpm_state_t;

    typedef enum logic [1:0] {
        CLK_HSI = 2'h0,
        CLK_HSE = 2'h1,
        CLK_MSI = 2'h2
    } lpm_clk_t;

    typedef struct packed {
        logic sleep_req;
        logic deep_sel;
        logic lpreg_sel;
    } lpm_core_req_t;

    typedef struct packed {
        logic reg_on;
        logic reg_lp;
        logic core_pwr;
        logic retain;
        logic cpu_clk;
        logic periph_clk;
        logic pll_en;
        logic multispeed_rc_osc;
        logic msi_min;
        logic high_speed_ext_osc;
        logic high_speed_int_osc;
        logic low_speed_ext_osc;
        logic low_speed_int_osc;
        logic rtc_clk;
        logic independent_watchdog_clk;
        logic lcd_en;
    } lpm_pwr_t;

    localparam lpm_pwr_t PWR_RST = 16'hC1FF & 16'hC0A8;

endpackage

// ---- tb/lpm_assertions.sv ----
/* lpm_chk: port checker for the low-power mode controller.
   Assumes a bind into lpm_ctrl. */
`timescale 1ns/1ps
module lpm_chk
    import lpm_pkg::*;
#(
    parameter int STANDBY_WAKE_CYC = 32
) (
    // clock and reset
    input wire logic               hclk,
    input wire logic               hresetn,
    // requests and wakeup sources
    input wire lpm_core_req_t      core_req,
    input wire logic [N_EVENT-1:0] external_event_line,
    input wire logic [N_PIN-1:0]   wakeup_pin,
    // power controls
    input wire lpm_pwr_t           pwr
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // cpu clock on marks a run mode, the only place a request is taken
    wire         go_w = core_req.sleep_req && pwr.cpu_clk;
    logic [15:0] stby_q;
    // ============================================================
    // standby exit time, counted from a wakeup pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) stby_q <= 16'h0;
        else if (pwr.core_pwr) stby_q <= 16'h0;
        else if (stby_q != 16'h0 || |wakeup_pin) stby_q <= stby_q + 16'h1;
    end
    // ============================================================
    // modes
    AST_RUN_SUPPLY: assert property (pwr.cpu_clk |-> pwr.core_pwr && pwr.reg_on)
        else $error("cpu clocked without supply");
    AST_SLEEP_IN: assert property (go_w && !core_req.deep_sel |->
        ##2 !pwr.cpu_clk && pwr.periph_clk) else $error("sleep entry wrong");
    AST_LP_SLEEP: assert property (go_w && !core_req.deep_sel && core_req.lpreg_sel |->
        ##2 pwr.reg_lp && !pwr.cpu_clk) else $error("low-power sleep entry wrong");
    AST_STOP_IN: assert property (go_w && core_req.deep_sel |-> ##2 !pwr.cpu_clk &&
        !pwr.pll_en && !pwr.multispeed_rc_osc && !pwr.high_speed_ext_osc)
        else $error("deep entry left a fast clock on");
    AST_WDG_KEPT: assert property (go_w && core_req.deep_sel |->
        ##2 pwr.independent_watchdog_clk == $past(pwr.independent_watchdog_clk, 2)) else $error("watchdog clock changed");
    AST_LCD_KEPT: assert property (go_w && core_req.deep_sel ##2 pwr.core_pwr |->
        pwr.lcd_en == $past(pwr.lcd_en, 2)) else $error("display stopped in stop");
    AST_STBY_OFF: assert property (!pwr.core_pwr && $past(hresetn) |-> !pwr.pll_en &&
        !pwr.high_speed_ext_osc && !pwr.high_speed_int_osc) else $error("standby clock on");
    AST_STOP_WAKE: assert property (|external_event_line && !pwr.cpu_clk && pwr.core_pwr
        |-> ##[1:875] pwr.cpu_clk) else $error("stop exit too slow");
    AST_STBY_EXIT: assert property (stby_q <= STANDBY_WAKE_CYC + WAKE_SLACK_CYC)
        else $error("standby exit too slow");
    cover property (go_w && core_req.deep_sel);
    cover property ($rose(pwr.core_pwr));
    cover property (go_w && core_req.lpreg_sel);
endmodule

// ---- tb/lpm_core_model.sv ----
/* lpm_core_model: processor core and wakeup sources facing lpm_ctrl.
   Assumes the bench calls its tasks just after a rising edge of hclk. */
`timescale 1ns/1ps
module lpm_core_model
    import lpm_pkg::*;
(
    // clock
    input  wire logic           hclk,
    // core requests
    output lpm_core_req_t       core_req,
    output logic                periph_irq,
    output logic                periph_hsi_req,
    // wakeup sources
    output logic [N_EVENT-1:0]  external_event_line,
    output logic [N_PIN-1:0]    wakeup_pin,
    output logic                external_reset_pin_n,
    output logic                independent_watchdog_rst,
    output logic [N_RTC_EV-1:0] rtc_event
);
    initial clr();
    // selects travel with the one-cycle pulse so both are sampled together
    task automatic sleep(input logic deep, input logic lp);
        @(posedge hclk);
        core_req <= '{1'b1, deep, lp};
        @(posedge hclk);
        core_req <= '0;
    endtask
    // source: 0 event line, 1 pin, 2 clock event, 3 interrupt, else fast osc request
    task automatic set(input int s, input int b);
        @(posedge hclk);
        case (s)
            0: external_event_line[b] <= 1'b1;
            1: wakeup_pin[b] <= 1'b1;
            2: rtc_event[b] <= 1'b1;
            3: periph_irq <= 1'b1;
            default: periph_hsi_req <= 1'b1;
        endcase
    endtask
    task automatic clr();
        core_req <= '0;
        {periph_irq, periph_hsi_req, independent_watchdog_rst} <= 3'h0;
        {external_event_line, wakeup_pin, rtc_event} <= '0;
        external_reset_pin_n <= 1'b1;
    endtask
endmodule

// ---- tb/tb.sv ----
/* tb: self-checking bench for the low-power mode controller.
   Assumes lpm_core_model drives the core and wakeup inputs. */
`timescale 1ns/1ps
module tb
    import lpm_pkg::*;
;
    localparam int SWC = 32;
    logic                hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_dp = 1'b0;
    logic [1:0]          htrans = 2'h0;
    logic [31:0]         haddr = 32'h0, hwdata = 32'h0, hrdata, exp_q[$];
    logic                hreadyout, hresp, core_wake, core_rst_n, irq, periph_irq, periph_hsi_req;
    logic                independent_watchdog_rst, external_reset_pin_n;
    logic [N_EVENT-1:0]  external_event_line;
    logic [N_PIN-1:0]    wakeup_pin;
    logic [N_RTC_EV-1:0] rtc_event;
    lpm_core_req_t       core_req;
    lpm_pwr_t            pwr;
    lpm_clk_t            sysclk_sel;
    int                  err_count = 0, n_checks = 0, k;
    always #2 hclk = ~hclk;
    lpm_ctrl #(.STANDBY_WAKE_CYC(SWC)) i_dut (.*, .hsize(3'h2), .hready(hreadyout));
    lpm_core_model p (.*);
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // ============================================================
    // bus master and read monitor
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, HTRANS_NONSEQ, w};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {htrans, hwdata} <= {2'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    always @(posedge hclk) begin
        if (rd_dp && hreadyout === 1'b1) cmp("hrdata", exp_q.pop_front(), hrdata);
        if (hsel && hreadyout === 1'b1) cmp("hresp", 32'h0, {31'h0, hresp});
        if (hreadyout === 1'b1) rd_dp = hsel && htrans == HTRANS_NONSEQ && !hwrite;
    end
    task automatic wt(input int n, input string nm);
        for (int i = 0; i < n && core_wake !== 1'b1; i++) @(posedge hclk);
        cmp(nm, 32'h1, {31'h0, core_wake});
        p.clr();
        repeat (3) @(posedge hclk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        results();
    end
    // ============================================================
    // tests
    initial begin
        void'($urandom(32'hEC71));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        cmp("run pwr", 32'h7, {pwr.reg_on, pwr.cpu_clk, pwr.core_pwr});
        k = $urandom & 32'h1FC;
        bus(1'b1, OFF_CFG, k);
        rd(OFF_CFG, k);
        bus(1'b1, 8'h10, 32'hFFFF_FFFF);
        rd(8'h10, 32'h0);
        bus(1'b1, OFF_IRQ_MASK, 32'h7);
        bus(1'b1, OFF_CFG, 32'h0);
        p.sleep(1'b0, 1'b0);
        repeat (3) @(posedge hclk);
        cmp("sleep pwr", 32'h9, {pwr.reg_on, pwr.reg_lp, pwr.cpu_clk, pwr.periph_clk});
        p.set(3, 0);
        wt(20, "sleep wake");
        cmp("irq", 32'h1, {31'h0, irq});
        rd(OFF_IRQ_STAT, 32'h1);
        rd(OFF_IRQ_STAT, 32'h0);
        $display("test sleep done");
        bus(1'b1, OFF_CFG, 32'h1);
        repeat (3) @(posedge hclk);
        cmp("lp run", 32'hB, {28'h0, sysclk_sel, pwr.reg_lp, pwr.msi_min});
        p.sleep(1'b0, 1'b1);
        repeat (3) @(posedge hclk);
        cmp("lp sleep", 32'h2, {pwr.reg_lp, pwr.cpu_clk});
        p.set(0, $urandom_range(N_EVENT - 1));
        wt(50, "lp wake");
        cmp("lp exit", 32'h1, {pwr.reg_lp, pwr.cpu_clk});
        rd(OFF_CFG, 32'h0);
        rd(OFF_IRQ_STAT, 32'h1);
        $display("test low-power done");
        for (k = 0; k < 2; k++) begin
            bus(1'b1, OFF_CFG, k ? 32'h9C : 32'h18);
            p.sleep(1'b1, 1'b0);
            repeat (3) @(posedge hclk);
            cmp("stop pwr", 32'h60, {pwr.reg_lp, pwr.retain, pwr.cpu_clk, pwr.pll_en,
                pwr.multispeed_rc_osc, pwr.high_speed_ext_osc, pwr.high_speed_int_osc});
            cmp("stop kept", {k[0], 2'h3}, {pwr.rtc_clk, pwr.independent_watchdog_clk, pwr.lcd_en});
            p.set(4, 0);
            repeat (2) @(posedge hclk);
            cmp("stop hsi", 32'h1, {31'h0, pwr.high_speed_int_osc});
            p.set(0, $urandom_range(N_EVENT - 1));
            wt(876, "stop wake");
            rd(OFF_IRQ_STAT, 32'h2);
        end
        $display("test stop done");
        for (k = 0; k < 2; k++) begin
            bus(1'b1, OFF_CFG, k ? 32'h86 : 32'h2);
            p.sleep(1'b1, 1'b0);
            repeat (3) @(posedge hclk);
            cmp("stby pwr", {k[0], k[0]}, {pwr.reg_on, pwr.core_pwr, pwr.pll_en,
                pwr.low_speed_ext_osc, pwr.rtc_clk});
            p.set(2, $urandom_range(N_RTC_EV - 1));
            if (k) wt(SWC + 20, "clock event wake");
            else begin
                repeat (SWC + 20) @(posedge hclk);
                cmp("no clock wake", 32'h0, {31'h0, pwr.core_pwr});
                p.clr();
                p.set(1, $urandom_range(N_PIN - 1));
                wt(SWC + 20, "pin wake");
            end
            rd(OFF_CFG, 32'h0);
            rd(OFF_CLK_CSR, k ? 32'h10041 : 32'h10021);
            bus(1'b1, OFF_CLK_CSR, 32'h1);
        end
        $display("test standby done");
        results();
    end
endmodule
bind lpm_ctrl lpm_chk #(.STANDBY_WAKE_CYC(STANDBY_WAKE_CYC)) i_chk (.*);
